//--- pkg/qbt_pkg.sv
package qbt_pkg;
    // Width of the transceiver slice.
    localparam int QBT_WIDTH = 4;
    // Driver register contents after reset.
    localparam logic [3:0] QBT_DRV_RESET = 4'h0;
    // Receiver latch contents after reset.
    localparam logic [3:0] QBT_RX_RESET = 4'h0;
    // Synchroniser depth for pin inputs.
    localparam int QBT_SYNC_STAGES = 2;
endpackage

//--- design/qbt_sync.sv
`timescale 1ns/10ps
// Two-stage synchroniser for pin inputs; the first stage feeds only the second.
module qbt_sync
    import qbt_pkg::*;
#(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] INIT = '0
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic ce,
    input wire logic [WIDTH-1:0] pin,
    output logic [WIDTH-1:0] sync
);
    logic [WIDTH-1:0] meta;

    // Both stages freeze with the clock enable and reset to a constant.
    always_ff @(posedge clk) begin
        if (!resetn) begin
            meta <= INIT;
            sync <= INIT;
        end else if (ce) begin
            meta <= pin;
            sync <= meta;
        end
    end
endmodule

//--- design/qbt_transceiver.sv
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////////////
module qbt_transceiver
    import qbt_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic ce,
    input wire logic [QBT_WIDTH-1:0] tx_in,
    input wire logic driver_reg_clock,
    input wire logic bus_drive_enable_n,
    input wire logic rx_latch_hold,
    input wire logic rx_out_enable_n,
    input wire logic [QBT_WIDTH-1:0] bus_in,
    output logic [QBT_WIDTH-1:0] bus_out,
    output logic [QBT_WIDTH-1:0] bus_oe,
    output logic [QBT_WIDTH-1:0] rx_out,
    output logic [QBT_WIDTH-1:0] rx_out_oe,
    output logic parity_out
);
    ////////////////////////////////////////////////////////////////////////////
    // All pins except clk, resetn and ce are asynchronous to clk, so each of those is synchronised first.
    localparam int NSYNC = 3 * QBT_WIDTH + 4;

    logic [NSYNC-1:0] pins_raw;
    logic [NSYNC-1:0] pins_s;
    logic [QBT_WIDTH-1:0] tx_s;
    logic [QBT_WIDTH-1:0] bus_s;
    logic [QBT_WIDTH-1:0] drv_echo_s;
    logic drclk_s;
    logic be_n_s;
    logic hold_s;
    logic oe_n_s;
    logic drclk_prev;
    logic [QBT_WIDTH-1:0] driver_reg_bit;
    logic [QBT_WIDTH-1:0] rx_latch_bit;

    // Synchronised pin bundle; tx data travels with its clock so they stay aligned.
    // The control bits reset to clock low, drive off, hold on and outputs off, so the
    // edge detector sees no false rise and no output enable pulses after reset.
    assign pins_raw = {tx_in, bus_in, driver_reg_bit, driver_reg_clock,
                       bus_drive_enable_n, rx_latch_hold, rx_out_enable_n};

    qbt_sync #(.WIDTH(NSYNC), .INIT({{(3*QBT_WIDTH){1'b0}}, 4'h7})) u_sync (
        .clk(clk),
        .resetn(resetn),
        .ce(ce),
        .pin(pins_raw),
        .sync(pins_s)
    );

    assign tx_s = pins_s[NSYNC-1 -: QBT_WIDTH];
    assign bus_s = pins_s[2*QBT_WIDTH+3 : QBT_WIDTH+4];
    assign drv_echo_s = pins_s[QBT_WIDTH+3:4];
    assign drclk_s = pins_s[3];
    assign be_n_s = pins_s[2];
    assign hold_s = pins_s[1];
    assign oe_n_s = pins_s[0];

    ////////////////////////////////////////////////////////////////////////////
    // Decoding of clock edge, latch source and parity.
    logic drclk_rise;
    logic [QBT_WIDTH-1:0] next_driver_reg_bit;
    logic [QBT_WIDTH-1:0] next_rx_latch_bit;
    logic next_parity;
    logic [QBT_WIDTH-1:0] rx_data;

    assign drclk_rise = drclk_s & ~drclk_prev;
    assign next_driver_reg_bit = drclk_rise ? tx_s : driver_reg_bit;
    // While we drive, the bus line is our own inverted bit; the echo avoids a pad read loop.
    assign rx_data = be_n_s ? ~bus_s : drv_echo_s;
    assign next_rx_latch_bit = hold_s ? rx_latch_bit : rx_data;
    assign next_parity = be_n_s ? ^rx_latch_bit : ^tx_s;

    ////////////////////////////////////////////////////////////////////////////
    // Driver register and edge detector; the driver clock is sampled synchronised.
    always_ff @(posedge clk) begin
        if (!resetn) begin
            drclk_prev <= 1'b0;
            driver_reg_bit <= QBT_DRV_RESET;
        end else if (ce) begin
            drclk_prev <= drclk_s;
            driver_reg_bit <= next_driver_reg_bit;
        end
    end

    // Receiver latch; hold uses the synchronised level to avoid a metastable enable.
    always_ff @(posedge clk) begin
        if (!resetn) begin
            rx_latch_bit <= QBT_RX_RESET;
        end else if (ce) begin
            rx_latch_bit <= next_rx_latch_bit;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pin outputs, all registered.
    always_ff @(posedge clk) begin
        if (!resetn) begin
            bus_out <= '0;
            bus_oe <= '0;
            rx_out <= '0;
            rx_out_oe <= '0;
            parity_out <= 1'b0;
        end else if (ce) begin
            bus_out <= ~next_driver_reg_bit;
            bus_oe <= {QBT_WIDTH{~be_n_s}};
            rx_out <= rx_latch_bit;
            rx_out_oe <= {QBT_WIDTH{~oe_n_s}};
            parity_out <= next_parity;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks on the behaviour above.
    AST_LOAD_ON_EDGE:
    assert property (@(posedge clk) disable iff (!resetn)
        ce && drclk_rise |=> driver_reg_bit == $past(tx_s))
    else $error("Driver register missed a clock edge load.");

    AST_HOLD_NO_EDGE:
    assert property (@(posedge clk) disable iff (!resetn)
        !drclk_rise |=> $stable(driver_reg_bit))
    else $error("Driver register changed without an edge.");

    AST_BUS_DRIVE:
    assert property (@(posedge clk) disable iff (!resetn)
        ce && !be_n_s |=> bus_oe == 4'hF && bus_out == ~driver_reg_bit)
    else $error("Bus not driven with inverted register.");

    AST_BUS_FLOAT:
    assert property (@(posedge clk) disable iff (!resetn)
        ce && be_n_s |=> bus_oe == 4'h0)
    else $error("Bus driver active while disabled.");

    AST_RX_FOLLOW:
    assert property (@(posedge clk) disable iff (!resetn)
        ce && !hold_s && be_n_s |=> rx_latch_bit == ~$past(bus_s))
    else $error("Receiver latch not following inverted bus.");

    AST_RX_OPEN_LOOP:
    assert property (@(posedge clk) disable iff (!resetn)
        ce && !hold_s && !be_n_s |=> rx_latch_bit == $past(drv_echo_s))
    else $error("Receiver latch not following driven data.");

    AST_RX_HOLD:
    assert property (@(posedge clk) disable iff (!resetn)
        hold_s |=> $stable(rx_latch_bit))
    else $error("Receiver latch changed while held.");

    AST_RX_OE:
    assert property (@(posedge clk) disable iff (!resetn)
        ce |=> rx_out_oe == {4{~$past(oe_n_s)}} && rx_out == $past(rx_latch_bit))
    else $error("Receiver output enable or data wrong.");

    AST_PAR_GEN:
    assert property (@(posedge clk) disable iff (!resetn)
        ce && !be_n_s |=> parity_out == ^$past(tx_s))
    else $error("Generated parity wrong.");

    AST_PAR_CHK:
    assert property (@(posedge clk) disable iff (!resetn)
        ce && be_n_s |=> parity_out == ^$past(rx_latch_bit))
    else $error("Checked parity wrong.");

    COV_LOAD: cover property (@(posedge clk) disable iff (!resetn) ce && drclk_rise);
    COV_DRIVE: cover property (@(posedge clk) disable iff (!resetn) ce && !be_n_s ##1 be_n_s);
    COV_HOLD: cover property (@(posedge clk) disable iff (!resetn) !hold_s ##1 hold_s [*3]);
endmodule

//--- verification/qbt_bus_party.sv
`timescale 1ns/10ps
// Far-side bus party; it answers one clock late, like a slow peer.
module qbt_bus_party
    import qbt_pkg::*;
(
    input wire logic clk,
    input wire logic bus_drive_enable_n,
    input wire logic want,
    input wire logic [QBT_WIDTH-1:0] data,
    output logic [QBT_WIDTH-1:0] drive,
    output logic [QBT_WIDTH-1:0] value
);
    always_ff @(posedge clk) begin
        drive <= {QBT_WIDTH{want & bus_drive_enable_n}};
        value <= data;
    end
endmodule

//--- verification/testbench.sv
`timescale 1ns/10ps
module testbench;
    import qbt_pkg::*;
    logic clk, resetn, ce, drc, be_n, hold, oe_n, want, par;
    logic [3:0] tx, pd, bin, bout, boe, rx, rxoe, pdrv, pv, drv, lat;
    int n_fail, tests_run, seed;
    ////////////////////////////////////////////////////////////////////////
    // Unowned lines are pulled up, so a floating bus reads as all ones.
    assign bin = (boe & bout) | (~boe & ((pdrv & pv) | ~pdrv));
    qbt_transceiver dut (.clk(clk), .resetn(resetn), .ce(ce), .tx_in(tx),
        .driver_reg_clock(drc), .bus_drive_enable_n(be_n), .rx_latch_hold(hold),
        .rx_out_enable_n(oe_n), .bus_in(bin), .bus_out(bout), .bus_oe(boe),
        .rx_out(rx), .rx_out_oe(rxoe), .parity_out(par));
    qbt_bus_party party (.clk(clk), .bus_drive_enable_n(be_n), .want(want),
        .data(pd), .drive(pdrv), .value(pv));
    ////////////////////////////////////////////////////////////////////////
    // Model of the bus level from the bench's own state.
    function automatic logic [3:0] mbus();
        return be_n ? (want ? pd : 4'hF) : ~drv;
    endfunction
    task automatic chk(input logic [3:0] got, input logic [3:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic finish_test();
        $display("mismatches %0d of %0d checks", n_fail, tests_run);
        if (n_fail == 0 && tests_run > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    // Free-running bench clock.
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // Watchdog; the whole sequence needs well under this span.
    initial begin
        repeat (20000) @(posedge clk);
        n_fail++;
        finish_test();
    end
    // Main sequence; waits of eight cycles cover the pin synchroniser lag.
    initial begin
        seed = 32'h53e52926;
        resetn = 1'b0;
        ce = 1'b1;
        drc = 1'b0;
        be_n = 1'b1;
        hold = 1'b0;
        oe_n = 1'b1;
        want = 1'b0;
        tx = 4'h0;
        pd = 4'h0;
        step(20);
        chk(boe | rxoe | rx, 4'h0);
        resetn = 1'b1;
        drv = QBT_DRV_RESET;
        lat = QBT_RX_RESET;
        step(8);
        for (int i = 0; i < 40; i++) begin
            hold = 1'($random(seed));
            step(8);
            if (!hold) lat = ~mbus();
            tx = 4'($random(seed));
            step(3);
            drc = 1'b1;
            step(3);
            drv = tx;
            tx = 4'($random(seed));
            step(3);
            drc = 1'b0;
            be_n = 1'($random(seed));
            oe_n = 1'($random(seed));
            want = 1'($random(seed));
            pd = 4'($random(seed));
            step(8);
            if (!hold) lat = ~mbus();
            chk(boe, be_n ? 4'h0 : 4'hF);
            if (!be_n) chk(bout, ~drv);
            chk(rxoe, oe_n ? 4'h0 : 4'hF);
            if (!oe_n) chk(rx, lat);
            chk({3'h0, par}, {3'h0, be_n ? ^lat : ^tx});
        end
        // Clock enable low freezes all state, so this driver clock pulse is lost.
        ce = 1'b0;
        tx = 4'($random(seed));
        step(3);
        drc = 1'b1;
        step(3);
        drc = 1'b0;
        step(3);
        ce = 1'b1;
        step(8);
        chk(boe, be_n ? 4'h0 : 4'hF);
        if (!be_n) chk(bout, ~drv);
        if (!oe_n) chk(rx, lat);
        chk({3'h0, par}, {3'h0, be_n ? ^lat : ^tx});
        finish_test();
    end
endmodule
